// ===== rtl/dsc_chan_mux.sv
/*
 * Channel code to analog input switch decoder, shared by both converters.
 * Assumes the caller registers the result; purely combinational.
 */
`timescale 1ns/1ps
module dsc_chan_mux
   import dsc_pkg::*;
(
   input wire logic [1:0] code_i,
   output dsc_sel_s sel_o
);
   function automatic dsc_sel_s decode(input logic [1:0] code);
      dsc_sel_s s;
      s.neg = IN_P0N;
      unique case (code)
         2'b00: s.pos = IN_P0P;
         2'b01: s.pos = IN_P1N;
         2'b10: s.pos = IN_P1P;
         2'b11: begin
            s.pos = IN_P1P;
            s.neg = IN_P1N;
         end
      endcase
      return s;
   endfunction

   always_comb begin
      sel_o = decode(code_i);
   end
endmodule

// ===== rtl/dsc_pkg.sv
/*
 * Shared constants and types of the dual converter conversion sequencer.
 * Assumes one system clock; every converter-side pin is synchronous to it.
 */
package dsc_pkg;
   // Conversion frame
   localparam int CONV_CYCLES = 12;
   localparam int PRECH_CYCLES = 1;
   localparam int MIN_ACQ_CYCLES = 2;
   localparam int FRAME_MIN_CYCLES = 16;
   localparam int CLK_STOP_EDGE = 16;
   localparam int DAC_STOP_EDGE = 14;

   // Clock rates
   localparam int REF_CLK_HZ = 20_000_000;
   localparam int CONV_CLK_MIN_HZ = 1_000_000;
   localparam int CONV_CLK_MAX_HZ = 32_000_000;

   // Serial configuration word
   localparam int CFG_BITS = 12;
   localparam int DAC_BITS = 10;
   localparam int DAC_STEP_UV = 2440;
   localparam logic [11:0] CFG_RESET = 12'h000;
   localparam logic [9:0] DAC_RESET = 10'h03FF;
   localparam logic [2:0] ACT_DAC_WR = 3'h1;
   localparam logic [2:0] ACT_DAC_RD = 3'h3;
   localparam logic [2:0] ACT_RESET = 3'h5;
   localparam logic [1:0] FEAT_UPDATE = 2'h1;

   // One-hot analog input selects
   localparam logic [3:0] IN_P0P = 4'h1;
   localparam logic [3:0] IN_P0N = 4'h2;
   localparam logic [3:0] IN_P1P = 4'h4;
   localparam logic [3:0] IN_P1N = 4'h8;

   typedef struct packed {
      logic [1:0] chan;
      logic [1:0] feat_en;
      logic [4:0] features;
      logic [2:0] action;
   } dsc_cfg_s;

   typedef struct packed {
      logic [3:0] pos;
      logic [3:0] neg;
   } dsc_sel_s;

   typedef enum logic [3:0] {
      ST_ACQ = 4'b0001,
      ST_HOLD = 4'b0010,
      ST_CONV = 4'b0100,
      ST_PRECH = 4'b1000
   } dsc_state_e;
endpackage

// ===== rtl/dsc_sequencer.sv
/*
 * Conversion sequencer for a dual simultaneous-sampling 12-bit SAR converter.
 * Assumes the converter clock, strobe, read pulse and serial input are
 * synchronous to ref_clk_i and slower than half its rate.
 */
`timescale 1ns/1ps
module dsc_sequencer
   import dsc_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic conv_clk_i,
   input wire logic conversion_strobe_i,
   input wire logic read_i,
   input wire logic serial_config_input_i,
   output logic busy_o,
   output logic sample_o,
   output logic precharge_o,
   output logic conv_done_o,
   output logic [3:0] sar_step_o,
   output dsc_sel_s sel_a_o,
   output dsc_sel_s sel_b_o,
   output logic [11:0] cfg_word_o,
   output logic [4:0] features_o,
   output logic [9:0] dac_code_o,
   output logic dac_read_o,
   output logic short_acq_o
);
   if (CONV_LEN < 1 || CONV_LEN > 15) begin : g_bad_len
      $error("CONV_LEN must be 1 to 15");
   end

   dsc_state_e state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic [1:0] acq_q, acq_d;
   logic clk_q, strb_q;
   logic [11:0] shift_q, shift_d;
   logic [3:0] bits_q, bits_d;
   logic shifting_q, shifting_d;
   dsc_cfg_s cfg_q, cfg_d;
   logic [4:0] feat_q, feat_d;
   logic [9:0] dac_q, dac_d;
   logic wr_arm_q, wr_arm_d, rd_arm_q, rd_arm_d;
   logic dac_read_q, dac_read_d, done_q, done_d, short_q, short_d;
   logic busy_q, sample_q, prech_q;
   dsc_sel_s sel_dec, sel_a_q, sel_b_q;
   logic clk_rise, clk_fall, strb_rise, word_done, soft_rst;
   logic [11:0] word;

   assign clk_rise = conv_clk_i & ~clk_q;
   assign clk_fall = ~conv_clk_i & clk_q;
   assign strb_rise = conversion_strobe_i & ~strb_q;
   assign word = {shift_q[10:0], serial_config_input_i};
   assign word_done = clk_fall & shifting_q & (bits_q == 4'(CFG_BITS - 1));
   assign soft_rst = word_done & ~wr_arm_q & (word[2:0] == ACT_RESET);

   // Serial configuration capture
   always_comb begin
      shift_d = shift_q;
      bits_d = bits_q;
      shifting_d = shifting_q;
      cfg_d = cfg_q;
      feat_d = feat_q;
      dac_d = dac_q;
      wr_arm_d = wr_arm_q;
      rd_arm_d = rd_arm_q;
      dac_read_d = 1'b0;
      if (clk_fall) begin
         if (!shifting_q && read_i) begin
            shift_d = word;
            bits_d = 4'h1;
            shifting_d = 1'b1;
            dac_read_d = rd_arm_q;
            rd_arm_d = 1'b0;
         end else if (shifting_q) begin
            shift_d = word;
            bits_d = bits_q + 4'h1;
         end
      end
      if (word_done) begin
         shifting_d = 1'b0;
         bits_d = 4'h0;
         if (wr_arm_q) begin
            dac_d = word[9:0];
            wr_arm_d = 1'b0;
         end else if (soft_rst) begin
            cfg_d = CFG_RESET;
            feat_d = 5'h00;
            dac_d = DAC_RESET;
            rd_arm_d = 1'b0;
         end else begin
            cfg_d = word;
            if (word[9:8] == FEAT_UPDATE) begin
               feat_d = word[7:3];
            end
            wr_arm_d = (word[2:0] == ACT_DAC_WR);
            rd_arm_d = (word[2:0] == ACT_DAC_RD);
         end
      end
   end

   // Conversion frame sequencing
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      acq_d = acq_q;
      done_d = 1'b0;
      short_d = short_q;
      unique case (state_q)
         ST_ACQ, ST_PRECH: begin
            if (strb_rise) begin
               state_d = ST_HOLD;
               short_d = (state_q == ST_PRECH) || (acq_q < 2'(MIN_ACQ_CYCLES));
            end else if (clk_rise) begin
               state_d = ST_ACQ;
               acq_d = (state_q == ST_PRECH) ? 2'h0 : ((acq_q == 2'h3) ? acq_q : acq_q + 2'h1);
            end
         end
         ST_HOLD: begin
            if (clk_rise) begin
               state_d = ST_CONV;
               cnt_d = 4'h0;
            end
         end
         ST_CONV: begin
            if (clk_rise) begin
               if (cnt_q == 4'(CONV_LEN - 1)) begin
                  state_d = ST_PRECH;
                  done_d = 1'b1;
               end else begin
                  cnt_d = cnt_q + 4'h1;
               end
            end
         end
      endcase
      if (soft_rst) begin
         state_d = ST_ACQ;
         cnt_d = 4'h0;
         acq_d = 2'h0;
         short_d = 1'b0;
      end
   end

   dsc_chan_mux u_mux (
      .code_i(cfg_d.chan),
      .sel_o(sel_dec)
   );

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= ST_ACQ;
         cnt_q <= 4'h0;
         acq_q <= 2'h0;
         clk_q <= 1'b0;
         strb_q <= 1'b0;
         shift_q <= 12'h000;
         bits_q <= 4'h0;
         shifting_q <= 1'b0;
         cfg_q <= CFG_RESET;
         feat_q <= 5'h00;
         dac_q <= DAC_RESET;
         wr_arm_q <= 1'b0;
         rd_arm_q <= 1'b0;
         dac_read_q <= 1'b0;
         done_q <= 1'b0;
         short_q <= 1'b0;
         busy_q <= 1'b0;
         sample_q <= 1'b1;
         prech_q <= 1'b0;
         sel_a_q <= {IN_P0P, IN_P0N};
         sel_b_q <= {IN_P0P, IN_P0N};
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         acq_q <= acq_d;
         clk_q <= conv_clk_i;
         strb_q <= conversion_strobe_i;
         shift_q <= shift_d;
         bits_q <= bits_d;
         shifting_q <= shifting_d;
         cfg_q <= cfg_d;
         feat_q <= feat_d;
         dac_q <= dac_d;
         wr_arm_q <= wr_arm_d;
         rd_arm_q <= rd_arm_d;
         dac_read_q <= dac_read_d;
         done_q <= done_d;
         short_q <= short_d;
         busy_q <= (state_d == ST_HOLD) || (state_d == ST_CONV);
         sample_q <= (state_d == ST_ACQ);
         prech_q <= (state_d == ST_PRECH);
         sel_a_q <= sel_dec;
         sel_b_q <= sel_dec;
      end
   end

   assign busy_o = busy_q;
   assign sample_o = sample_q;
   assign precharge_o = prech_q;
   assign conv_done_o = done_q;
   assign sar_step_o = cnt_q;
   assign sel_a_o = sel_a_q;
   assign sel_b_o = sel_b_q;
   assign cfg_word_o = cfg_q;
   assign features_o = feat_q;
   assign dac_code_o = dac_q;
   assign dac_read_o = dac_read_q;
   assign short_acq_o = short_q;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   a_busy_on_strobe: assert property (
      state_q == ST_ACQ && strb_rise && !soft_rst |=> busy_o && !sample_o)
      else $error("busy did not rise on strobe");
   a_strobe_ignored: assert property (
      state_q == ST_CONV && strb_rise && !clk_rise && !soft_rst |=> $stable(cnt_q) && busy_o)
      else $error("strobe disturbed running conversion");
   a_conv_end: assert property (
      state_q == ST_CONV && clk_rise && cnt_q == 4'(CONV_LEN - 1) && !soft_rst
      |=> !busy_o && precharge_o && conv_done_o)
      else $error("conversion end not marked");
   a_prech_one: assert property (
      precharge_o && clk_rise && !strb_rise && !soft_rst |=> sample_o && !precharge_o)
      else $error("precharge longer than one cycle");
   a_acq_low: assert property (
      sample_o |-> !busy_o)
      else $error("busy high during acquisition");
   a_conv_start: assert property (
      state_q == ST_HOLD && clk_rise && !soft_rst |=> state_q == ST_CONV && cnt_q == 4'h0)
      else $error("conversion did not start at clock rise");
   a_mux_shared: assert property (
      sel_a_o == sel_b_o)
      else $error("converters select different inputs");
   a_mux_full: assert property (
      (cfg_q.chan == 2'b11) [*2] |-> sel_a_o.pos == IN_P1P && sel_a_o.neg == IN_P1N)
      else $error("code 11 does not select pair 1");
   a_mux_pseudo: assert property (
      (cfg_q.chan == 2'b01) [*2] |-> sel_a_o.pos == IN_P1N && sel_a_o.neg == IN_P0N)
      else $error("code 01 wrong input");
   a_soft_reset: assert property (
      soft_rst |=> cfg_word_o == CFG_RESET && dac_code_o == DAC_RESET && sample_o)
      else $error("software reset incomplete");
   a_falling_only: assert property (
      !clk_fall |=> $stable(bits_q))
      else $error("serial bit taken off a falling edge");
   a_stopped_clock: assert property (
      $stable(conv_clk_i) && !strb_rise |=> $stable(state_q))
      else $error("state moved with stopped clock");
   a_dac_load: assert property (
      word_done && wr_arm_q |=> dac_code_o == $past(word[9:0]) && !wr_arm_q)
      else $error("DAC code not loaded");
   a_dac_hold: assert property (
      $stable(conv_clk_i) |=> $stable(dac_code_o))
      else $error("DAC code moved with stopped clock");
   a_short_flag: assert property (
      state_q == ST_ACQ && acq_q < 2'(MIN_ACQ_CYCLES) && strb_rise && !soft_rst
      |=> short_acq_o)
      else $error("short acquisition not flagged");
   a_busy_cause: assert property (
      !busy_o && !strb_rise |=> !busy_o)
      else $error("busy rose without a strobe");
   a_read_pulse: assert property (
      dac_read_o |=> !dac_read_o)
      else $error("DAC read pulse longer than one cycle");
   a_feat_keep: assert property (
      word_done && word[9:8] != FEAT_UPDATE && !soft_rst |=> $stable(features_o))
      else $error("features changed without update code");
   a_step_range: assert property (
      sar_step_o <= 4'(CONV_LEN - 1))
      else $error("conversion step out of range");

   c_full_frame: cover property (conv_done_o ##[1:40] sample_o);
   c_short_acq: cover property ($rose(short_acq_o));
   c_dac_write: cover property (word_done && wr_arm_q);
   c_soft_reset: cover property (soft_rst);
   c_strobe_in_conv: cover property (state_q == ST_CONV && strb_rise);
endmodule

// ===== sim/dsc_host.sv
/*
 * Host model: drives the converter clock, strobe, read pulse and serial input.
 * Assumes ref_clk_i at 20 MHz; every change lands at its falling edge.
 */
`timescale 1ns/1ps
module dsc_host (
   input wire logic ref_clk_i,
   output logic conv_clk_o,
   output logic strobe_o,
   output logic read_o,
   output logic ser_cfg_o
);
   initial begin
      conv_clk_o = 1'b0;
      strobe_o = 1'b0;
      read_o = 1'b0;
      ser_cfg_o = 1'b0;
   end

   // One 2.5 MHz period, clock parked low afterwards
   task automatic tick();
      conv_clk_o = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      conv_clk_o = 1'b0;
      repeat (4) @(negedge ref_clk_i);
   endtask

   task automatic send_word(input logic [11:0] w);
      @(negedge ref_clk_i);
      read_o = 1'b1;
      for (int i = 11; i >= 0; i--) begin
         ser_cfg_o = w[i];
         tick();
         read_o = 1'b0;
      end
      // Released line must not keep showing the last bit
      ser_cfg_o = ~w[0];
   endtask

   // Sixteen clocks per frame; twice raises the strobe again while busy
   task automatic convert(input bit twice);
      @(negedge ref_clk_i);
      strobe_o = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      tick();
      strobe_o = 1'b0;
      for (int k = 2; k <= 16; k++) begin
         if (twice && k == 6) begin
            // Off the clock rise, so the ignored strobe is seen alone
            @(negedge ref_clk_i);
            strobe_o = 1'b1;
            @(negedge ref_clk_i);
         end
         if (twice && k == 8) strobe_o = 1'b0;
         tick();
      end
   endtask

   // Strobe and read tied together, raised with a clock rise
   task automatic convert_read(input logic [11:0] w);
      @(negedge ref_clk_i);
      strobe_o = 1'b1;
      read_o = 1'b1;
      for (int k = 1; k <= 16; k++) begin
         ser_cfg_o = (k <= 12) ? w[12 - k] : ~w[0];
         tick();
         strobe_o = 1'b0;
         read_o = 1'b0;
      end
   endtask
endmodule

// ===== sim/tb_dual_sar_conversion_sequencer.sv
/*
 * Self-checking bench of the dual converter conversion sequencer.
 * Assumes the host model dsc_host drives the converter-side inputs.
 */
`timescale 1ns/1ps
module tb_dual_sar_conversion_sequencer;
   import dsc_pkg::*;
   localparam int CL = 12;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic conv_clk, strobe, rd_pulse, ser_cfg, busy, sample, prech, done, dac_rd, short_acq;
   logic [3:0] step;
   dsc_sel_s sel_a, sel_b;
   logic [11:0] cfg, w;
   logic [4:0] feat, f_exp;
   logic [9:0] dac;
   logic cclk_q = 1'b0;
   logic busy_q = 1'b0;
   int num_errors = 0;
   int n_checks = 0;
   int seed = 16730;
   int rises, busy_up, pre_cyc, dones, reads, overlap;

   always #25 ref_clk = ~ref_clk;

   dsc_host u_host (.ref_clk_i(ref_clk), .conv_clk_o(conv_clk), .strobe_o(strobe),
      .read_o(rd_pulse), .ser_cfg_o(ser_cfg));

   dsc_sequencer #(.CONV_LEN(CL)) u_dut (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
      .conv_clk_i(conv_clk), .conversion_strobe_i(strobe), .read_i(rd_pulse),
      .serial_config_input_i(ser_cfg), .busy_o(busy), .sample_o(sample), .precharge_o(prech),
      .conv_done_o(done), .sar_step_o(step), .sel_a_o(sel_a), .sel_b_o(sel_b),
      .cfg_word_o(cfg), .features_o(feat), .dac_code_o(dac), .dac_read_o(dac_rd),
      .short_acq_o(short_acq));

   always @(posedge ref_clk) begin
      if (conv_clk && !cclk_q && busy) rises++;
      if (busy && !busy_q) busy_up++;
      if (prech) pre_cyc++;
      if (done) dones++;
      if (dac_rd) reads++;
      if (busy && sample) overlap++;
      cclk_q <= conv_clk;
      busy_q <= busy;
   end

   task automatic check(input string nm, input logic [11:0] e, input logic [11:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   function automatic dsc_sel_s exp_sel(input logic [1:0] c);
      case (c)
         2'b00: return '{pos: IN_P0P, neg: IN_P0N};
         2'b01: return '{pos: IN_P1N, neg: IN_P0N};
         2'b10: return '{pos: IN_P1P, neg: IN_P0N};
         default: return '{pos: IN_P1P, neg: IN_P1N};
      endcase
   endfunction

   task automatic put(input logic [11:0] v);
      u_host.send_word(v);
      repeat (3) @(negedge ref_clk);
   endtask

   task automatic cfg_chk(input logic [11:0] v);
      put(v);
      if (v[9:8] == FEAT_UPDATE) f_exp = v[7:3];
      check("cfg_word", v, cfg);
      check("sel_a", {4'h0, exp_sel(v[11:10])}, {4'h0, sel_a});
      check("sel_b", {4'h0, exp_sel(v[11:10])}, {4'h0, sel_b});
      check("features", 12'(f_exp), 12'(feat));
   endtask

   task automatic conv(input int mode, input logic [11:0] v);
      rises = 0;
      busy_up = 0;
      pre_cyc = 0;
      dones = 0;
      overlap = 0;
      if (mode == 2) begin
         u_host.convert_read(v);
      end else begin
         u_host.convert(mode == 1);
      end
      repeat (2) @(negedge ref_clk);
      check("busy_rises", 12'h001, 12'(busy_up));
      check("busy_clocks", 12'(CL + 1), 12'(rises));
      check("precharge_len", 12'h008, 12'(pre_cyc));
      check("done_pulses", 12'h001, 12'(dones));
      check("busy_sample", 12'h000, 12'(overlap));
      check("sample_end", 12'h001, 12'(sample));
      check("sar_step", 12'(CL - 1), 12'(step));
      if (mode == 1) check("short_acq", 12'h000, 12'(short_acq));
   endtask

   initial begin
      f_exp = 5'h00;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_b = 1'b1;
      check("busy", 12'h000, 12'(busy));
      check("sample", 12'h001, 12'(sample));
      check("dac", {2'b00, DAC_RESET}, {2'b00, dac});
      check("cfg", CFG_RESET, cfg);
      for (int c = 0; c < 4; c++) begin
         cfg_chk({2'(c), 10'h000});
         conv(0, 12'h000);
      end
      conv(1, 12'h000);
      put({9'h000, ACT_DAC_WR});
      w = 12'($random(seed));
      u_host.send_word(w);
      u_host.tick();
      u_host.tick();
      check("dac", {2'b00, w[9:0]}, {2'b00, dac});
      reads = 0;
      put({9'h000, ACT_DAC_RD});
      put(12'h000);
      check("dac_read", 12'h001, 12'(reads));
      for (int i = 0; i < 10; i++) begin
         w = 12'($random(seed));
         if (w[9:8] == 2'b10) w[9:8] = FEAT_UPDATE;
         // Even action codes are all no-action
         w[0] = 1'b0;
         cfg_chk(w);
      end
      w = 12'($random(seed));
      w[9:8] = 2'b00;
      w[2:0] = 3'h0;
      conv(2, w);
      check("cfg_word", w, cfg);
      check("sel_a", {4'h0, exp_sel(w[11:10])}, {4'h0, sel_a});
      conv(0, w);
      check("short_acq", 12'h001, 12'(short_acq));
      put({9'h000, ACT_DAC_WR});
      put(12'h155);
      put({9'h000, ACT_RESET});
      f_exp = 5'h00;
      check("dac", {2'b00, DAC_RESET}, {2'b00, dac});
      check("cfg", CFG_RESET, cfg);
      check("features", 12'h000, 12'(feat));
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      $display("[ERR] watchdog expected done seen hang");
      complete_run();
   end
endmodule
